/* src/rmas_regs.svh */
`ifndef RMAS_REGS_SVH
`define RMAS_REGS_SVH
// ------------------------------------------------------------
// Register byte offsets on the Avalon-MM slave
// ------------------------------------------------------------
`define RMAS_OFF_CMD   5'h00
`define RMAS_OFF_CW    5'h04
`define RMAS_OFF_ADA   5'h08
`define RMAS_OFF_ADD   5'h0c
`define RMAS_OFF_NW    5'h10
`define RMAS_OFF_AVG   5'h14
// ------------------------------------------------------------
// Command and status fields
// ------------------------------------------------------------
`define RMAS_CMD_COND  2
`define RMAS_ST_BUSY   0
`define RMAS_ST_FAULT  1
`define RMAS_ST_ZERO   2
`define RMAS_IND_BIT   16
// ------------------------------------------------------------
// Control word bits
// ------------------------------------------------------------
`define RMAS_B_POS     15
`define RMAS_B_SGN     15
`define RMAS_B_LOW     14
`define RMAS_B_BIN     14
`define RMAS_B_BYTE    13
`define RMAS_B_SKIP    12
// ------------------------------------------------------------
// Memory map of the data areas (word addresses)
// ------------------------------------------------------------
`define RMAS_DATA_LO   16'h1000
`define RMAS_DATA_HI   16'h29ff
`define RMAS_XTRA_LO   16'h2a00
`define RMAS_XTRA_HI   16'h3fff
`define RMAS_AR_IO     2'h0
`define RMAS_AR_DATA   2'h1
`define RMAS_AR_XTRA   2'h2
`define RMAS_AR_NONE   2'h3
`define RMAS_AVG_MAX   10'h040
`define RMAS_AVG_CLIP  10'h041
`endif

/* src/rmas_pkg.sv */
package rmas_pkg;
	// Operation selected by the command write.
	typedef enum logic [1:0] {OP_MIN, OP_AVG, OP_SUM, OP_NONE} rmas_op_type;
	// What the word being fetched is for.
	typedef enum logic [1:0] {PH_PTR, PH_SRC, PH_SCAN} rmas_ph_type;
	typedef enum logic [3:0] {
		S_IDLE, S_CHK, S_SET, S_RD, S_WT, S_DAT, S_WS, S_W0, S_W1, S_FIN
	} rmas_st_type;
	// One request toward the data memory.
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} rmas_mem_type;
endpackage : rmas_pkg

/* src/rmas_unit.sv */
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "rmas_regs.svh"
// How it works
// - with execution condition false, an operation changes nothing.
// - minimum search scans N words, writes the smallest to destination.
// - control bit 15 adds position at destination+1: address or offset.
// - control bit 14 reports the lowest address among equal minima.
// - search count is three low BCD digits, 001 to 999.
// - search compares unsigned when bit 15 clear, signed when set.
// - signed search ranks words from 8000 hex upward as negative.
// - search faults on bad pointer, boundary overrun or split range.
// - search sets zero flag when the minimum is 0000.
// - averager count is BCD 0001 to 0064; larger counts act as 64.
// - each run stores source at next slot from destination+2.
// - from run N on, mean of samples goes to destination.
// - mean is binary, rounded to nearest, halves rounded up.
// - averager faults on bad pointer, bad operand or split buffer.
// - total goes to destination and next word in input form.
// - bit 13 selects word or byte items; N counts those items.
// - bytes go upper first; bit 12 skips first upper byte.
// - bit 14 clear BCD, bit 14 set unsigned, 14 and 15 signed.
// - total faults on bad pointer, split range, bad count, bad BCD.
// - total sets zero flag when the result is zero.
module rmas_unit (
	input  wire logic                 ref_clk_in,
	input  wire logic                 rstn_in,
	input  wire logic [4:0]           avs_address_in,
	input  wire logic                 avs_read_in,
	input  wire logic                 avs_write_in,
	input  wire logic [31:0]          avs_writedata_in,
	input  wire logic [3:0]           avs_byteenable_in,
	output logic      [31:0]          avs_readdata_out,
	output logic                      avs_waitrequest_out,
	output rmas_pkg::rmas_mem_type    mem_out,
	input  wire logic [15:0]          mem_rdata_in,
	output logic                      busy_out,
	output logic                      fault_flag_out,
	output logic                      zero_result_flag_out
);
	import rmas_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic isbcd(input logic [15:0] w);
		isbcd = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (w[4*i+:4] > 4'h9) isbcd = 1'b0;
		end
	endfunction : isbcd

	function automatic logic [13:0] bcd2bin(input logic [15:0] w);
		int r;
		r = 0;
		for (int i = 3; i >= 0; i--) begin
			r = r * 10 + int'(w[4*i+:4]);
		end
		bcd2bin = 14'(r);
	endfunction : bcd2bin

	// Constant divisors only, so this folds into plain logic.
	function automatic logic [15:0] bin2bcd(input logic [15:0] b);
		int v;
		v = int'(b);
		for (int i = 0; i < 4; i++) begin
			bin2bcd[4*i+:4] = 4'(v % 10);
			v = v / 10;
		end
	endfunction : bin2bcd

	function automatic logic [31:0] bcdadd(input logic [31:0] a,
			input logic [31:0] b);
		logic [4:0] s;
		logic       c;
		c = 1'b0;
		for (int i = 0; i < 8; i++) begin
			s = {1'b0, a[4*i+:4]} + {1'b0, b[4*i+:4]} + {4'h0, c};
			c = s > 5'd9;
			bcdadd[4*i+:4] = c ? 4'(s - 5'd10) : s[3:0];
		end
	endfunction : bcdadd

	function automatic logic [1:0] area(input logic [15:0] a);
		if (a < `RMAS_DATA_LO) area = `RMAS_AR_IO;
		else if (a <= `RMAS_DATA_HI) area = `RMAS_AR_DATA;
		else if (a <= `RMAS_XTRA_HI) area = `RMAS_AR_XTRA;
		else area = `RMAS_AR_NONE;
	endfunction : area

	function automatic logic [31:0] merge(input logic [31:0] o,
			input logic [31:0] n, input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			merge[8*i+:8] = be[i] ? n[8*i+:8] : o[8*i+:8];
		end
	endfunction : merge

	// ------------------------------------------------------------
	// Register file and Avalon-MM slave
	// ------------------------------------------------------------
	logic        wreq_reg;
	logic [15:0] cw_reg;
	logic [16:0] ada_reg;
	logic [15:0] add_reg;
	logic [15:0] nw_reg;
	logic [6:0]  acnt_reg;
	logic [6:0]  slot_reg;
	rmas_op_type op_reg;
	rmas_st_type st_reg;
	logic        busy_reg;
	logic        flt_reg;
	logic        zero_reg;
	logic        stall;
	logic        wr_ok;
	logic        go;
	logic [31:0] wmix;

	// A command write while busy is held off until the run ends; operand
	// register writes are not held off and take effect during a run.
	assign stall = avs_write_in && avs_address_in == `RMAS_OFF_CMD
		&& busy_reg;
	assign wr_ok = avs_write_in && !wreq_reg;
	assign wmix = merge(32'h0, avs_writedata_in, avs_byteenable_in);
	assign go = wr_ok && avs_address_in == `RMAS_OFF_CMD
		&& wmix[`RMAS_CMD_COND] && wmix[1:0] != 2'(OP_NONE);

	// Wait state: answer one cycle after the request is seen.
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) wreq_reg <= 1'b1;
		else if (wreq_reg && (avs_read_in || avs_write_in) && !stall)
			wreq_reg <= 1'b0;
		else wreq_reg <= 1'b1;
	end

	// Read data is latched with the wait state drop.
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) avs_readdata_out <= 32'h0;
		else if (wreq_reg && avs_read_in) begin
			unique case (avs_address_in)
				`RMAS_OFF_CMD: avs_readdata_out <= {29'h0, zero_reg,
					flt_reg, busy_reg};
				`RMAS_OFF_CW:  avs_readdata_out <= {16'h0, cw_reg};
				`RMAS_OFF_ADA: avs_readdata_out <= {15'h0, ada_reg};
				`RMAS_OFF_ADD: avs_readdata_out <= {16'h0, add_reg};
				`RMAS_OFF_NW:  avs_readdata_out <= {16'h0, nw_reg};
				`RMAS_OFF_AVG: avs_readdata_out <= {25'h0, acnt_reg};
				default:       avs_readdata_out <= 32'h0;
			endcase
		end
	end

	// Operand registers; unmapped writes are dropped.
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			cw_reg  <= 16'h0;
			ada_reg <= 17'h0;
			add_reg <= 16'h0;
			nw_reg  <= 16'h0;
			op_reg  <= OP_NONE;
		end else if (wr_ok) begin
			unique case (avs_address_in)
				`RMAS_OFF_CW: cw_reg <= 16'(merge({16'h0, cw_reg},
					avs_writedata_in, avs_byteenable_in));
				`RMAS_OFF_ADA: ada_reg <= 17'(merge({15'h0, ada_reg},
					avs_writedata_in, avs_byteenable_in));
				`RMAS_OFF_ADD: add_reg <= 16'(merge({16'h0, add_reg},
					avs_writedata_in, avs_byteenable_in));
				`RMAS_OFF_NW: nw_reg <= 16'(merge({16'h0, nw_reg},
					avs_writedata_in, avs_byteenable_in));
				`RMAS_OFF_CMD: if (go) op_reg <= rmas_op_type'(wmix[1:0]);
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	rmas_ph_type ph_reg;
	rmas_mem_type mem_reg;
	logic [15:0] base_reg;
	logic [15:0] cur_reg;
	logic [9:0]  n_reg;
	logic [9:0]  left_reg;
	logic [31:0] acc_reg;
	logic [15:0] best_reg;
	logic [15:0] bpos_reg;
	logic        first_reg;
	logic        bsel_reg;
	logic [15:0] smp_reg;
	logic [9:0]  nbcd;
	logic [9:0]  nwv;
	logic [9:0]  nw_eff;
	logic [9:0]  words;
	logic [15:0] last;
	logic        bad_n;
	logic        bsum;
	logic [15:0] item;
	logic [31:0] itx;
	logic        lt;
	logic        better;
	logic [21:0] mean;
	logic [15:0] pos;
	logic [15:0] res1;
	logic [6:0]  slot;
	logic [15:0] tgt;

	assign nbcd = 10'(bcd2bin({4'h0, cw_reg[11:0]}));
	assign nwv  = 10'(bcd2bin(nw_reg) > 14'(`RMAS_AVG_MAX)
		? `RMAS_AVG_MAX : 10'(bcd2bin(nw_reg)));
	assign nw_eff = nwv;
	assign words = cw_reg[`RMAS_B_BYTE]
		? 10'((11'(nbcd) + {10'h0, cw_reg[`RMAS_B_SKIP]} + 11'h1) >> 1)
		: nbcd;
	assign last = op_reg == OP_AVG ? add_reg + 16'(nw_eff) + 16'h1
		: base_reg + 16'(words) - 16'h1;
	assign bad_n = op_reg == OP_AVG
		? (!isbcd(nw_reg) || nw_reg == 16'h0)
		: (!isbcd({4'h0, cw_reg[11:0]}) || nbcd == 10'h0);
	assign bsum = cw_reg[`RMAS_B_BYTE];
	assign item = bsum ? {8'h0, bsel_reg ? mem_rdata_in[15:8]
		: mem_rdata_in[7:0]} : mem_rdata_in;
	// sign extension only in signed binary
	assign itx = !(cw_reg[`RMAS_B_BIN] && cw_reg[`RMAS_B_SGN]) ? {16'h0, item}
		: bsum ? {{24{item[7]}}, item[7:0]} : {{16{item[15]}}, item};
	assign lt = cw_reg[`RMAS_B_SGN] ? $signed(mem_rdata_in) < $signed(best_reg)
		: mem_rdata_in < best_reg;
	assign better = first_reg || lt
		|| (!cw_reg[`RMAS_B_LOW] && mem_rdata_in == best_reg);
	assign mean = (22'(acc_reg) + 22'(n_reg >> 1)) / 22'(n_reg);
	assign pos = area(bpos_reg) == `RMAS_AR_DATA
		? bin2bcd(bpos_reg - `RMAS_DATA_LO) : bin2bcd(bpos_reg - base_reg);
	assign res1 = op_reg == OP_MIN ? best_reg
		: op_reg == OP_SUM ? acc_reg[15:0] : mean[15:0];
	assign slot = slot_reg >= 7'(n_reg) ? 7'h0 : slot_reg;
	// Indirect target is the pointer's own area base plus the pointer, so
	// the same sum serves the boundary check and the new range start.
	assign tgt = (area(ada_reg[15:0]) == `RMAS_AR_DATA ? `RMAS_DATA_LO
		: `RMAS_XTRA_LO) + 16'(bcd2bin(mem_rdata_in));

	// Main sequence. Faults abort before any destination write.
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			st_reg <= S_IDLE;
			ph_reg <= PH_SCAN;
			busy_reg <= 1'b0;
			flt_reg <= 1'b0;
			zero_reg <= 1'b0;
			mem_reg <= '0;
			base_reg <= 16'h0;
			cur_reg <= 16'h0;
			n_reg <= 10'h1;
			left_reg <= 10'h0;
			acc_reg <= 32'h0;
			best_reg <= 16'h0;
			bpos_reg <= 16'h0;
			first_reg <= 1'b1;
			bsel_reg <= 1'b0;
			smp_reg <= 16'h0;
		end else begin
			mem_reg.rd <= 1'b0;
			mem_reg.wr <= 1'b0;
			unique case (st_reg)
				S_IDLE: if (go) begin
					busy_reg <= 1'b1;
					st_reg <= S_CHK;
				end
				S_CHK: begin
					base_reg <= ada_reg[15:0];
					cur_reg <= ada_reg[15:0];
					ph_reg <= PH_PTR;
					st_reg <= ada_reg[`RMAS_IND_BIT] ? S_RD : S_SET;
				end
				S_SET: begin
					acc_reg <= 32'h0;
					first_reg <= 1'b1;
					bsel_reg <= !cw_reg[`RMAS_B_SKIP];
					n_reg <= op_reg == OP_AVG ? nw_eff : nbcd;
					left_reg <= op_reg == OP_AVG ? nw_eff : nbcd;
					cur_reg <= base_reg;
					ph_reg <= op_reg == OP_AVG ? PH_SRC : PH_SCAN;
					if (bad_n || area(last) == `RMAS_AR_NONE
							|| area(op_reg == OP_AVG ? add_reg : base_reg)
							!= area(last)) begin
						flt_reg <= 1'b1;
						st_reg <= S_FIN;
					end else st_reg <= S_RD;
				end
				S_RD: begin
					mem_reg.rd <= 1'b1;
					mem_reg.addr <= cur_reg;
					st_reg <= S_WT;
				end
				S_WT: st_reg <= S_DAT;
				S_DAT: begin
					unique case (ph_reg)
						PH_PTR: begin
							if (!isbcd(mem_rdata_in) || area(ada_reg[15:0])
									== `RMAS_AR_IO
									|| area(tgt) != area(ada_reg[15:0])) begin
								flt_reg <= 1'b1;
								st_reg <= S_FIN;
							end else begin
								base_reg <= tgt;
								st_reg <= S_SET;
							end
						end
						PH_SRC: begin
							smp_reg <= mem_rdata_in;
							st_reg <= S_WS;
						end
						PH_SCAN: begin
							if (op_reg == OP_MIN && better) begin
								best_reg <= mem_rdata_in;
								bpos_reg <= cur_reg;
							end
							first_reg <= 1'b0;
							if (op_reg == OP_AVG) acc_reg <= acc_reg + itx;
							else if (!cw_reg[`RMAS_B_BIN])
								acc_reg <= bcdadd(acc_reg, itx);
							else acc_reg <= acc_reg + itx;
							if (op_reg == OP_SUM && !cw_reg[`RMAS_B_BIN]
									&& !isbcd(item)) begin
								flt_reg <= 1'b1;
								st_reg <= S_FIN;
							end else begin
								if (op_reg == OP_SUM && bsum && bsel_reg)
									bsel_reg <= 1'b0;
								else begin
									bsel_reg <= 1'b1;
									cur_reg <= cur_reg + 16'h1;
								end
								left_reg <= left_reg - 10'h1;
								st_reg <= left_reg == 10'h1 ? S_W0 : S_RD;
							end
						end
						default: st_reg <= S_FIN;
					endcase
				end
				S_WS: begin
					mem_reg.wr <= 1'b1;
					mem_reg.addr <= add_reg + 16'h2 + 16'(slot);
					mem_reg.wdata <= smp_reg;
					cur_reg <= add_reg + 16'h2;
					ph_reg <= PH_SCAN;
					// mean only from run N on
					st_reg <= 10'(acnt_reg) + 10'h1 >= n_reg ? S_RD : S_FIN;
				end
				S_W0: begin
					mem_reg.wr <= 1'b1;
					mem_reg.addr <= add_reg;
					mem_reg.wdata <= res1;
					if (op_reg == OP_MIN) zero_reg <= best_reg == 16'h0;
					if (op_reg == OP_SUM) zero_reg <= acc_reg == 32'h0;
					st_reg <= op_reg == OP_SUM || (op_reg == OP_MIN
						&& cw_reg[`RMAS_B_POS]) ? S_W1 : S_FIN;
				end
				S_W1: begin
					mem_reg.wr <= 1'b1;
					mem_reg.addr <= add_reg + 16'h1;
					mem_reg.wdata <= op_reg == OP_SUM ? acc_reg[31:16] : pos;
					st_reg <= S_FIN;
				end
				S_FIN: begin
					busy_reg <= 1'b0;
					st_reg <= S_IDLE;
				end
				default: st_reg <= S_IDLE;
			endcase
			if (st_reg == S_IDLE && go) flt_reg <= 1'b0;
		end
	end

	// Averager run count and ring slot; a count write restarts the ring.
	// destination+1 is never touched here
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in || (wr_ok && avs_address_in == `RMAS_OFF_NW)) begin
			acnt_reg <= 7'h0;
			slot_reg <= 7'h0;
		end else if (st_reg == S_WS) begin
			if (10'(acnt_reg) < `RMAS_AVG_MAX) acnt_reg <= acnt_reg + 7'h1;
			slot_reg <= 10'(slot) + 10'h1 >= n_reg ? 7'h0 : slot + 7'h1;
		end
	end

	assign avs_waitrequest_out = wreq_reg;
	assign mem_out = mem_reg;
	assign busy_out = busy_reg;
	assign fault_flag_out = flt_reg;
	assign zero_result_flag_out = zero_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_nocond;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		!busy_reg && wr_ok && avs_address_in == `RMAS_OFF_CMD
			&& !wmix[`RMAS_CMD_COND] |=> !busy_reg ##1 !busy_reg;
	endproperty
	a_nocond: assert property (p_nocond)
		else $error("Run started with condition false.");

	property p_idlewr;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		!busy_reg && !$past(busy_reg) |-> !mem_reg.wr;
	endproperty
	a_idlewr: assert property (p_idlewr)
		else $error("Memory written while idle.");

	property p_nofltwr;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		flt_reg && busy_reg |-> st_reg != S_W0 && st_reg != S_W1;
	endproperty
	a_nofltwr: assert property (p_nofltwr)
		else $error("Destination written after a fault.");

	property p_badn;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		st_reg == S_SET && op_reg != OP_AVG && cw_reg[11:0] == 12'h0
			|=> flt_reg && st_reg == S_FIN ##1 !busy_reg;
	endproperty
	a_badn: assert property (p_badn)
		else $error("Zero item count did not fault.");

	property p_clip;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		st_reg == S_SET && op_reg == OP_AVG && isbcd(nw_reg)
			&& nw_reg >= 16'h0065 |=> n_reg == `RMAS_AVG_MAX;
	endproperty
	a_clip: assert property (p_clip)
		else $error("Large sample count not clipped to 64.");

	property p_slot;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		st_reg == S_WS |=> mem_reg.wr
			&& mem_reg.addr == add_reg + 16'h2 + 16'($past(slot));
	endproperty
	a_slot: assert property (p_slot)
		else $error("Sample stored at wrong slot.");

	property p_nopos;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		st_reg == S_W0 && op_reg == OP_MIN && !cw_reg[`RMAS_B_POS]
			|=> st_reg == S_FIN ##1 !busy_reg;
	endproperty
	a_nopos: assert property (p_nopos)
		else $error("Position written without bit 15.");

	property p_zero;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		st_reg == S_W0 && op_reg == OP_SUM
			|=> zero_reg == ($past(acc_reg) == 32'h0);
	endproperty
	a_zero: assert property (p_zero)
		else $error("Zero flag disagrees with total.");

	property p_minzero;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		st_reg == S_W0 && op_reg == OP_MIN
			|=> zero_reg == (mem_reg.wdata == 16'h0);
	endproperty
	a_minzero: assert property (p_minzero)
		else $error("Zero flag disagrees with minimum.");

	property p_range;
		@(posedge ref_clk_in) disable iff (!rstn_in)
		mem_reg.rd && op_reg == OP_MIN && ph_reg == PH_SCAN
			|-> mem_reg.addr >= base_reg
			&& mem_reg.addr < base_reg + 16'(n_reg);
	endproperty
	a_range: assert property (p_range)
		else $error("Search read outside its range.");

	c_minpos: cover property (@(posedge ref_clk_in)
		st_reg == S_W1 && op_reg == OP_MIN);
	c_mean: cover property (@(posedge ref_clk_in)
		st_reg == S_W0 && op_reg == OP_AVG);
	c_bytes: cover property (@(posedge ref_clk_in)
		st_reg == S_W1 && op_reg == OP_SUM && bsum);
	c_fault: cover property (@(posedge ref_clk_in)
		st_reg == S_FIN && flt_reg);
endmodule : rmas_unit

/* testbench/rmas_mem_model.sv */
`timescale 1ns/1ps
// Word memory on the far side of the unit, with one cycle of read latency.
module rmas_mem_model
	import rmas_pkg::*;
(
	input  wire logic                   clk_in,
	input  wire rmas_pkg::rmas_mem_type req_in,
	output logic [15:0]                 rdata_out
);
	logic [15:0] mem [0:16383];

	// Start from a clean image so that no unread word is unknown.
	initial begin
		for (int k = 0; k < 16384; k++) begin
			mem[k] = 16'h0000;
		end
	end

	// Read data stands for one cycle only; it then flips, so that a late
	// sample never matches by luck.
	// no own writes
	always @(posedge clk_in) begin
		rdata_out <= req_in.rd ? mem[req_in.addr[13:0]] : ~rdata_out;
		if (req_in.wr) begin
			mem[req_in.addr[13:0]] <= req_in.wdata;
		end
	end
endmodule : rmas_mem_model

/* testbench/range_min_avg_sum_unit_test.sv */
`timescale 1ns/1ps
module range_min_avg_sum_unit_test;
	import rmas_pkg::*;
	logic         ref_clk = 1'b0;
	logic         rstn    = 1'b0;
	logic [4:0]   av_a    = 5'h00;
	logic         av_rd   = 1'b0;
	logic         av_wr   = 1'b0;
	logic [31:0]  av_wd   = 32'h0;
	logic [31:0]  av_q;
	logic         av_wait;
	logic [31:0]  bus_q;
	rmas_mem_type m_req;
	logic [15:0]  m_rd;
	logic         busy;
	logic         flt;
	logic         zro;
	int           err_total = 0;
	int           tests_run = 0;

	// Free running 20 MHz clock.
	always #25 ref_clk = ~ref_clk;

	rmas_unit u_rmas_unit (
		.ref_clk_in(ref_clk), .rstn_in(rstn), .avs_address_in(av_a),
		.avs_read_in(av_rd), .avs_write_in(av_wr), .avs_writedata_in(av_wd),
		.avs_byteenable_in(4'hf), .avs_readdata_out(av_q),
		.avs_waitrequest_out(av_wait), .mem_out(m_req), .mem_rdata_in(m_rd),
		.busy_out(busy), .fault_flag_out(flt), .zero_result_flag_out(zro));

	rmas_mem_model u_rmas_mem_model (
		.clk_in(ref_clk), .req_in(m_req), .rdata_out(m_rd));

	// -----------------------------------------------------------------
	// Shared tasks
	// -----------------------------------------------------------------
	task wrap_up;
		if (err_total == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task tmo;
		err_total++;
		$display("Error handshake expected answer seen none");
		wrap_up();
	endtask : tmo

	// The request stands until waitrequest is sampled low at an edge.
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk);
		av_a <= a;
		av_wr <= w;
		av_rd <= ~w;
		av_wd <= d;
		for (i = 0; i < 40; i++) begin
			@(posedge ref_clk);
			if (av_wait === 1'b0) break;
		end
		if (i == 40) tmo();
		bus_q = av_q;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
	endtask : bus

	task run(input logic [1:0] op, input logic c);
		int i;
		bus(1'b1, 5'h00, {29'h0, c, op});
		for (i = 0; i < 9000; i++) begin
			@(posedge ref_clk);
			if (busy === 1'b0) break;
		end
		if (i == 9000) tmo();
	endtask : run

	task setup(input logic [15:0] cw, input logic [16:0] a,
		input logic [15:0] d);
		bus(1'b1, 5'h04, {16'h0, cw});
		bus(1'b1, 5'h08, {15'h0, a});
		bus(1'b1, 5'h0c, {16'h0, d});
	endtask : setup

	task ld(input logic [15:0] a, input logic [15:0] v[$]);
		foreach (v[k]) u_rmas_mem_model.mem[a[13:0] + 14'(k)] = v[k];
	endtask : ld

	function logic [31:0] mv(input logic [15:0] a);
		return {16'h0, u_rmas_mem_model.mem[a[13:0]]};
	endfunction : mv

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task t_min;
		ld(16'h1010, '{16'h0007, 16'h8000, 16'h0003, 16'h8000, 16'h0003});
		ld(16'h0100, '{16'h0005, 16'h0000, 16'h0002});
		setup(16'h0005, 17'h01010, 16'h1100);
		run(2'd0, 1'b1);
		chk("min_unsigned", mv(16'h1100), 32'h3);
		chk("zero_clear", 32'(zro), 32'h0);
		setup(16'h8005, 17'h01010, 16'h1100);
		run(2'd0, 1'b1);
		chk("min_signed", mv(16'h1100), 32'h8000);
		chk("pos_data", mv(16'h1101), 32'h19);
		setup(16'hc005, 17'h01010, 16'h1100);
		run(2'd0, 1'b1);
		chk("pos_lowest", mv(16'h1101), 32'h17);
		setup(16'hc003, 17'h00100, 16'h1100);
		run(2'd0, 1'b1);
		chk("min_io", mv(16'h1100), 32'h0);
		chk("pos_offset", mv(16'h1101), 32'h1);
		chk("zero_set", 32'(zro), 32'h1);
	endtask : t_min

	task t_fault;
		ld(16'h1020, '{16'h00ab});
		ld(16'h1100, '{16'h5555});
		setup(16'h0005, 17'h029fe, 16'h1100);
		run(2'd0, 1'b1);
		chk("fault_span", 32'(flt), 32'h1);
		chk("dest_kept", mv(16'h1100), 32'h5555);
		setup(16'h0001, 17'h11020, 16'h1100);
		run(2'd0, 1'b1);
		chk("fault_ptr", 32'(flt), 32'h1);
		bus(1'b0, 5'h00, 32'h0);
		chk("status_fault", 32'(bus_q[1]), 32'h1);
		bus(1'b0, 5'h18, 32'h0);
		chk("unmapped", bus_q, 32'h0);
		ld(16'h1010, '{16'h0001});
		setup(16'h0001, 17'h01010, 16'h1100);
		run(2'd0, 1'b0);
		chk("cond_off_dest", mv(16'h1100), 32'h5555);
		chk("cond_off_flag", 32'(flt), 32'h1);
		run(2'd0, 1'b1);
		chk("cond_on_dest", mv(16'h1100), 32'h1);
		ld(16'h1022, '{16'h0020});
		setup(16'h0001, 17'h11022, 16'h1100);
		run(2'd0, 1'b1);
		chk("ptr_target", mv(16'h1100), 32'h3);
		chk("ptr_ok_flag", 32'(flt), 32'h0);
	endtask : t_fault

	task t_sum;
		logic [15:0] t [0:8][0:5];
		int i;
		t = '{'{16'h0002, 16'h9999, 16'h0001, 16'h0000, 16'h0001, 16'h0},
			'{16'h4002, 16'hffff, 16'h0003, 16'h0002, 16'h0001, 16'h0},
			'{16'hc002, 16'hffff, 16'h0001, 16'h0000, 16'h0000, 16'h0},
			'{16'hc002, 16'hffff, 16'hfffe, 16'hfffd, 16'hffff, 16'h0},
			'{16'h6003, 16'h0102, 16'h0304, 16'h0006, 16'h0000, 16'h0},
			'{16'h7003, 16'h0102, 16'h0304, 16'h0009, 16'h0000, 16'h0},
			'{16'h2003, 16'h1299, 16'h0100, 16'h0112, 16'h0000, 16'h0},
			'{16'h0002, 16'h00a0, 16'h0001, 16'h5555, 16'h5555, 16'h1},
			'{16'h4000, 16'h0001, 16'h0001, 16'h5555, 16'h5555, 16'h1}};
		for (i = 0; i < 9; i++) begin
			ld(16'h1200, '{t[i][1], t[i][2]});
			ld(16'h1210, '{16'h5555, 16'h5555});
			setup(t[i][0], 17'h01200, 16'h1210);
			run(2'd2, 1'b1);
			chk("sum_lo", mv(16'h1210), {16'h0, t[i][3]});
			chk("sum_hi", mv(16'h1211), {16'h0, t[i][4]});
			chk("sum_fault", 32'(flt), 32'(t[i][5][0]));
			if (t[i][5][0] == 1'b0) begin
				chk("sum_zero", 32'(zro), 32'(t[i][3] == 0 && t[i][4] == 0));
			end
		end
	endtask : t_sum

	task t_avg;
		int i;
		ld(16'h1300, '{16'h5555, 16'h0000});
		ld(16'h1342, '{16'h5555});
		setup(16'h0000, 17'h01030, 16'h1300);
		bus(1'b1, 5'h10, 32'h3);
		for (i = 0; i < 4; i++) begin
			ld(16'h1030, '{16'(i)});
			run(2'd1, 1'b1);
			chk("slot", mv(16'h1302 + 16'(i % 3)), 32'(i));
			chk("mean", mv(16'h1300), (i < 2) ? 32'h5555 : 32'(i - 1));
		end
		chk("aux_word", mv(16'h1301), 32'h0);
		bus(1'b1, 5'h10, 32'h2);
		for (i = 1; i < 3; i++) begin
			ld(16'h1030, '{16'(i)});
			run(2'd1, 1'b1);
		end
		chk("mean_half_up", mv(16'h1300), 32'h2);
		bus(1'b1, 5'h10, 32'h99);
		ld(16'h1030, '{16'h0001});
		for (i = 0; i < 65; i++) begin
			run(2'd1, 1'b1);
		end
		bus(1'b0, 5'h14, 32'h0);
		chk("run_count", bus_q, 32'h40);
		chk("slot_limit", mv(16'h1342), 32'h5555);
		chk("mean_sat", mv(16'h1300), 32'h1);
		bus(1'b1, 5'h10, 32'h0);
		run(2'd1, 1'b1);
		chk("avg_fault", 32'(flt), 32'h1);
	endtask : t_avg

	// Reset, then every scenario in turn.
	initial begin
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		chk("reset_wait", 32'(av_wait), 32'h1);
		t_min();
		t_fault();
		t_sum();
		t_avg();
		wrap_up();
	end
endmodule : range_min_avg_sum_unit_test
